/* File: rtl/dsb_bank.sv */
// drive status and fault history parameter bank with parameter-number access
`timescale 1ns/1ps
`include "dsb_cfg.svh"

module dsb_bank (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // parameter access port from the network side
  input wire logic prm_req,
  input wire logic prm_we,
  input wire logic [8:0] prm_num,
  input wire logic [31:0] prm_wdata,
  output logic prm_ack_r,
  output logic prm_err_r,
  output logic [31:0] prm_rdata_r,
  // drive state inputs
  input wire logic pos_mode,
  input wire logic pos_above_home,
  input wire logic [15:0] status2_in,
  input wire logic [15:0] feature_in,
  // live measurements
  input wire logic [15:0] slip_in,
  input wire logic [31:0] speed_whole_in,
  input wire logic [15:0] speed_frac_in,
  input wire logic [31:0] fb_speed_whole_in,
  input wire logic [15:0] fb_speed_frac_in,
  input wire logic [31:0] travel_whole_in,
  input wire logic [15:0] travel_frac_in,
  // fault reports
  input wire logic fault_vld,
  input wire dsb_pkg::dsb_fault_code_t fault_code,
  // selected command and status word layout
  output dsb_pkg::dsb_layout_t word_layout,
  // drive status second word as presented
  output logic [15:0] status2_word,
  // fault history slot one to three, kept elsewhere for display
  output dsb_pkg::dsb_fault_code_t [2:0] fault_recent,
  output logic fault_recorded
);
  import dsb_pkg::*;

  // layout selector register
  dsb_layout_t word_layout_select_r;
  dsb_layout_t word_layout_select_nxt;

  // status words held for reading
  logic [15:0] drive_status_second_r;
  logic [15:0] drive_status_second_nxt;
  logic [15:0] feature_status_r;

  // monitor values
  logic [15:0] slip_monitor_q;
  logic [31:0] speed_fb_whole_q;
  logic [15:0] speed_fb_frac_q;
  logic [31:0] feedback_speed_whole_q;
  logic [15:0] feedback_speed_frac_q;
  logic [31:0] travel_whole_q;
  logic [15:0] travel_frac_q;

  // fault history
  dsb_fault_code_t [`DSB_HIST_DEPTH-1:0] hist_slot;

  // access decode
  logic num_is_layout;
  logic num_is_hist;
  logic num_mapped;
  logic wr_ok;
  logic acc_err;
  logic [3:0] hist_idx;
  logic [31:0] rd_mux;
  logic [31:0] prm_rdata_nxt;

  // zero-extend a 16-bit word to the read data width
  function automatic logic [31:0] ext16(input logic [15:0] v);
    ext16 = {16'h0000, v};
  endfunction : ext16

  // zero-extend a fault code to the read data width
  function automatic logic [31:0] ext_code(input dsb_fault_code_t v);
    ext_code = {25'h0000000, v};
  endfunction : ext_code

  // ---- monitors
  // [RQ3] slip tenths of a hertz
  dsb_monitor #(.W(16), .MAX(`DSB_SLIP_MAX)) u_slip (
    .core_clk(core_clk),
    .rst(rst),
    .val(slip_in),
    .q_r(slip_monitor_q)
  );

  // [RQ4] actual speed whole part
  dsb_monitor #(.W(32), .MAX(`DSB_SPEED_MAX)) u_spd_w (
    .core_clk(core_clk),
    .rst(rst),
    .val(speed_whole_in),
    .q_r(speed_fb_whole_q)
  );

  // [RQ5] actual speed tenths
  dsb_monitor #(.W(16), .MAX(`DSB_TENTHS_MAX)) u_spd_f (
    .core_clk(core_clk),
    .rst(rst),
    .val(speed_frac_in),
    .q_r(speed_fb_frac_q)
  );

  // [RQ6] feedback device speed whole part
  dsb_monitor #(.W(32), .MAX(`DSB_SPEED_MAX)) u_fbs_w (
    .core_clk(core_clk),
    .rst(rst),
    .val(fb_speed_whole_in),
    .q_r(feedback_speed_whole_q)
  );

  // [RQ7] feedback device speed tenths
  dsb_monitor #(.W(16), .MAX(`DSB_TENTHS_MAX)) u_fbs_f (
    .core_clk(core_clk),
    .rst(rst),
    .val(fb_speed_frac_in),
    .q_r(feedback_speed_frac_q)
  );

  // [RQ8] distance from home whole units
  dsb_monitor #(.W(32), .MAX(`DSB_SPEED_MAX)) u_trv_w (
    .core_clk(core_clk),
    .rst(rst),
    .val(travel_whole_in),
    .q_r(travel_whole_q)
  );

  // [RQ9] distance from home hundredths
  dsb_monitor #(.W(16), .MAX(`DSB_HUNDREDTHS_MAX)) u_trv_f (
    .core_clk(core_clk),
    .rst(rst),
    .val(travel_frac_in),
    .q_r(travel_frac_q)
  );

  // ---- fault history
  dsb_fault_hist #(.DEPTH(`DSB_HIST_DEPTH)) u_hist (
    .core_clk(core_clk),
    .rst(rst),
    .fault_vld(fault_vld),
    .fault_code(fault_code),
    .slot_r(hist_slot),
    .recorded(fault_recorded)
  );

  assign fault_recent = hist_slot[2:0];

  // ---- status word second
  // [RQ2] side of home replaces bit 10 in positioning mode
  always_comb begin
    drive_status_second_nxt = status2_in;
    if (pos_mode) begin
      drive_status_second_nxt[`DSB_HOME_SIDE_BIT] = pos_above_home;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      drive_status_second_r <= 16'h0000;
      feature_status_r <= 16'h0000;
    end else begin
      drive_status_second_r <= drive_status_second_nxt;
      feature_status_r <= feature_in;
    end
  end

  assign status2_word = drive_status_second_r;

  // ---- access decode
  assign num_is_layout = (prm_num == `DSB_PN_LAYOUT);
  assign num_is_hist = (prm_num >= `DSB_PN_HIST_FIRST) && (prm_num <= `DSB_PN_HIST_LAST);
  assign num_mapped = num_is_layout || ((prm_num >= `DSB_PN_STATUS2) && (prm_num <= `DSB_PN_HIST_LAST));
  // slot four sits at the first history number
  assign hist_idx = 4'(prm_num - `DSB_PN_HIST_FIRST) + 4'(`DSB_HIST_SHOWN_FIRST);
  // [RQ1] only 0 or 1 is accepted into the selector
  assign wr_ok = num_is_layout && (prm_wdata <= `DSB_LAYOUT_MAX);
  // [RQ3] monitors refuse writes
  assign acc_err = !num_mapped || (prm_we && !wr_ok);

  // [RQ1] selector update on an accepted write
  assign word_layout_select_nxt = (prm_req && prm_we && wr_ok) ? dsb_layout_t'(prm_wdata[0]) : word_layout_select_r;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      word_layout_select_r <= dsb_layout_t'(`DSB_LAYOUT_RST);
    end else begin
      word_layout_select_r <= word_layout_select_nxt;
    end
  end

  assign word_layout = word_layout_select_r;

  // ---- read selection
  always_comb begin
    rd_mux = 32'h00000000;
    case (prm_num)
      `DSB_PN_LAYOUT: rd_mux = {31'h00000000, word_layout_select_r};
      `DSB_PN_STATUS2: rd_mux = ext16(drive_status_second_r);
      `DSB_PN_FEATURE: rd_mux = ext16(feature_status_r);
      `DSB_PN_SLIP: rd_mux = ext16(slip_monitor_q);
      `DSB_PN_SPD_W: rd_mux = speed_fb_whole_q;
      `DSB_PN_SPD_F: rd_mux = ext16(speed_fb_frac_q);
      `DSB_PN_FBS_W: rd_mux = feedback_speed_whole_q;
      `DSB_PN_FBS_F: rd_mux = ext16(feedback_speed_frac_q);
      `DSB_PN_TRV_W: rd_mux = travel_whole_q;
      `DSB_PN_TRV_F: rd_mux = ext16(travel_frac_q);
      default: begin
        if (num_is_hist) begin
          rd_mux = ext_code(hist_slot[hist_idx]);
        end
      end
    endcase
  end

  // read data only on an accepted read, else zero
  assign prm_rdata_nxt = (prm_req && !prm_we && num_mapped) ? rd_mux : 32'h00000000;

  // one answer per request, one cycle later
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prm_ack_r <= 1'b0;
      prm_err_r <= 1'b0;
      prm_rdata_r <= 32'h00000000;
    end else begin
      prm_ack_r <= prm_req;
      prm_err_r <= prm_req && acc_err;
      prm_rdata_r <= prm_rdata_nxt;
    end
  end

  // ---- checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_layout_write(logic [31:0] v);
    prm_req && prm_we && num_is_layout && prm_wdata == v;
  endsequence

  a_layout_pos: assert property (s_layout_write(32'h00000001) |=> word_layout == DSB_LAYOUT_POSITION) // [RQ1]
    else $error("layout did not go to position");
  a_layout_vel: assert property (s_layout_write(32'h00000000) |=> word_layout == DSB_LAYOUT_VELOCITY) // [RQ1]
    else $error("layout did not go to velocity");
  a_home_side: assert property (pos_mode |=> status2_word[`DSB_HOME_SIDE_BIT] == $past(pos_above_home)) // [RQ2]
    else $error("bit 10 does not show home side");
  a_ro_refused: assert property (prm_req && prm_we && !num_is_layout |=> prm_ack_r && prm_err_r) // [RQ3]
    else $error("write to read-only parameter not refused");
  a_speed_read: assert property (prm_req && !prm_we && prm_num == `DSB_PN_SPD_W // [RQ4]
    |=> prm_rdata_r == $past(speed_fb_whole_q) && prm_rdata_r <= `DSB_SPEED_MAX)
    else $error("speed whole read wrong");
  a_speed_frac: assert property (speed_fb_frac_q <= `DSB_TENTHS_MAX) // [RQ5]
    else $error("speed tenths out of range");
  a_fb_follow: assert property (fb_speed_whole_in <= `DSB_SPEED_MAX // [RQ6]
    |=> feedback_speed_whole_q == $past(fb_speed_whole_in))
    else $error("feedback speed not refreshed");
  a_fb_frac: assert property (feedback_speed_frac_q <= `DSB_TENTHS_MAX) // [RQ7]
    else $error("feedback tenths out of range");
  a_travel_whole: assert property (travel_whole_q <= `DSB_SPEED_MAX) // [RQ8]
    else $error("travel count out of range");
  a_travel_frac: assert property (travel_frac_q <= `DSB_HUNDREDTHS_MAX) // [RQ9]
    else $error("travel hundredths out of range");
  a_hist_read: assert property (prm_req && !prm_we && prm_num == `DSB_PN_HIST_LAST && !fault_recorded // [RQ13]
    |=> prm_rdata_r == ext_code(hist_slot[9]))
    else $error("slot ten read wrong");
  a_ack_once: assert property (prm_req |=> prm_ack_r ##1 (prm_ack_r == $past(prm_req))) // one answer per request, one cycle later
    else $error("access answer timing wrong");

endmodule : dsb_bank

/* File: rtl/dsb_cfg.svh */
// parameter numbers, ranges, reset values and bit positions of the drive status bank
// Notes on behaviour
// [RQ1] layout selector 0 picks velocity word layout (default), 1 picks position layout
// [RQ2] in positioning mode status-2 bit 10 shows side of home
// [RQ3] slip monitor is read-only, 0.0 to 25.0 Hz in 0.1 Hz steps
// [RQ4] speed whole monitor is read-only 32-bit, 0 to 64000 RPM, measured or estimated
// [RQ5] speed fractional monitor is read-only tenths, 0.0 to 0.9
// [RQ6] feedback speed whole monitor read-only 32-bit, 0 to 64000, always updated
// [RQ7] feedback speed fractional monitor is read-only tenths, 0.0 to 0.9
// [RQ8] travel whole monitor is read-only 32-bit count 0 to 64000 from home
// [RQ9] travel fractional monitor is read-only hundredths, 0.00 to 0.99
// [RQ10] history slots hold read-only codes 0 to 122, newest in slot one
// [RQ11] a fault repeating the newest recorded one is recorded once only
// [RQ12] on a new fault slots four to nine shift one place older
// [RQ13] on a new fault slot ten drops its code and takes slot nine
// [RQ14] the whole ten-deep history shifts in one clock cycle
`ifndef DSB_CFG_SVH
`define DSB_CFG_SVH

// parameter numbers used on the access port
`define DSB_PN_LAYOUT 9'h0f9
`define DSB_PN_STATUS2 9'h12d
`define DSB_PN_FEATURE 9'h12e
`define DSB_PN_SLIP 9'h12f
`define DSB_PN_SPD_W 9'h130
`define DSB_PN_SPD_F 9'h131
`define DSB_PN_FBS_W 9'h132
`define DSB_PN_FBS_F 9'h133
`define DSB_PN_TRV_W 9'h134
`define DSB_PN_TRV_F 9'h135
`define DSB_PN_HIST_FIRST 9'h136
`define DSB_PN_HIST_LAST 9'h13c

// ranges and reset values
`define DSB_LAYOUT_RST 1'h0
`define DSB_LAYOUT_MAX 32'h00000001
`define DSB_SLIP_MAX 16'h00fa
`define DSB_SPEED_MAX 32'h0000fa00
`define DSB_TENTHS_MAX 16'h0009
`define DSB_HUNDREDTHS_MAX 16'h0063
`define DSB_FAULT_MAX 7'h7a
`define DSB_FAULT_NONE 7'h00

// history geometry and status bit position
`define DSB_HIST_DEPTH 10
`define DSB_HIST_SHOWN_FIRST 3
`define DSB_HOME_SIDE_BIT 10

`endif

/* File: rtl/dsb_fault_hist.sv */
// ten-deep fault history, newest in slot one, repeats recorded once
`timescale 1ns/1ps
`include "dsb_cfg.svh"

module dsb_fault_hist #(
  parameter int DEPTH = `DSB_HIST_DEPTH
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // fault report from drive logic
  input wire logic fault_vld,
  input wire dsb_pkg::dsb_fault_code_t fault_code,
  // history, index 0 is slot one
  output dsb_pkg::dsb_fault_code_t [DEPTH-1:0] slot_r,
  output logic recorded
);
  import dsb_pkg::*;

  logic code_ok;
  logic is_repeat;

  // [RQ10] only codes 1 to 122 enter
  assign code_ok = (fault_code != `DSB_FAULT_NONE) && (fault_code <= `DSB_FAULT_MAX);
  // [RQ11] same as newest is not recorded again
  assign is_repeat = (fault_code == slot_r[0]);
  assign recorded = fault_vld && code_ok && !is_repeat;

  // [RQ14] single-cycle shift of all slots
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      slot_r <= '0;
    end else if (recorded) begin
      // [RQ12] [RQ13] each slot takes the newer one
      slot_r <= {slot_r[DEPTH-2:0], fault_code};
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_new_fault;
    recorded;
  endsequence

  sequence s_repeat_fault;
    fault_vld && is_repeat;
  endsequence

  a_hist_range: assert property (slot_r[0] <= `DSB_FAULT_MAX) // [RQ10]
    else $error("history holds code above range");
  a_hist_repeat: assert property (s_repeat_fault |=> $stable(slot_r)) // [RQ11]
    else $error("repeated fault shifted the history");
  a_hist_middle: assert property (s_new_fault |=> slot_r[8:3] == $past(slot_r[7:2])) // [RQ12]
    else $error("slots four to nine did not shift");
  a_hist_oldest: assert property (s_new_fault |=> slot_r[9] == $past(slot_r[8])) // [RQ13]
    else $error("slot ten did not take slot nine");
  a_hist_one_step: assert property (s_new_fault // [RQ14]
    |=> slot_r[0] == $past(fault_code) && slot_r[3] == $past(slot_r[2]))
    else $error("history did not shift in one cycle");
  a_hist_idle: assert property (!fault_vld |=> $stable(slot_r)) // [RQ10]
    else $error("history changed without a fault");

endmodule : dsb_fault_hist

/* File: rtl/dsb_monitor.sv */
// read-only monitor word, clamped to its range and refreshed every cycle
`timescale 1ns/1ps
`include "dsb_cfg.svh"

module dsb_monitor #(
  parameter int W = 16,
  parameter logic [W-1:0] MAX = '1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // live value from drive logic
  input wire logic [W-1:0] val,
  // held monitor value
  output logic [W-1:0] q_r
);
  import dsb_pkg::*;

  logic [W-1:0] q_nxt;

  // [RQ6] refresh every cycle
  assign q_nxt = (val > MAX) ? MAX : val;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_mon_bound: assert property (q_r <= MAX) // [RQ3]
    else $error("monitor above its range");
  a_mon_follow: assert property (val <= MAX |=> q_r == $past(val)) // [RQ6]
    else $error("monitor did not follow live value");
  a_mon_clamp: assert property (val > MAX |=> q_r == MAX) // [RQ4]
    else $error("monitor not clamped to maximum");

endmodule : dsb_monitor

/* File: rtl/dsb_pkg.sv */
// types shared by the drive status bank
package dsb_pkg;

  // command and status word layout choice
  typedef enum logic {
    DSB_LAYOUT_VELOCITY = 1'b0,
    DSB_LAYOUT_POSITION = 1'b1
  } dsb_layout_t;

  // fault code as carried inside the history
  typedef logic [6:0] dsb_fault_code_t;

endpackage : dsb_pkg

/* File: tb/dsb_host.sv */
// network host model issuing parameter accesses to the bank
`timescale 1ns/1ps

module dsb_host (
  // clock
  input wire logic core_clk,
  // access answer from the bank
  input wire logic prm_ack_r,
  input wire logic prm_err_r,
  input wire logic [31:0] prm_rdata_r,
  // access request to the bank
  output logic prm_req,
  output logic prm_we,
  output logic [8:0] prm_num,
  output logic [31:0] prm_wdata
);
  // idle request lines at time zero
  initial begin
    prm_req = 1'b0;
    prm_we = 1'b0;
    prm_num = 9'h000;
    prm_wdata = 32'h00000000;
  end

  // one access: request for one cycle, then a bounded wait for the answer
  task automatic acc(input logic we, input logic [8:0] num, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er, output logic ok);
    int i;
    ok = 1'b0;
    rd = 32'h00000000;
    er = 1'b1;
    @(negedge core_clk);
    prm_req = 1'b1;
    prm_we = we;
    prm_num = num;
    prm_wdata = wd;
    @(negedge core_clk);
    // released data lines no longer show the last value
    prm_req = 1'b0;
    prm_wdata = ~wd;
    prm_num = ~num;
    for (i = 0; i < 3 && !ok; i++) begin
      if (prm_ack_r === 1'b1) begin
        ok = 1'b1;
        rd = prm_rdata_r;
        er = prm_err_r;
      end else begin
        @(negedge core_clk);
      end
    end
  endtask : acc
endmodule : dsb_host

/* File: tb/tb_dsb_bank.sv */
// self-checking bench for the drive status and fault history bank
`timescale 1ns/1ps
`include "dsb_cfg.svh"

module tb_dsb_bank;
  import dsb_pkg::*;
  // design connections
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic prm_req, prm_we, prm_ack_r, prm_err_r;
  logic [8:0] prm_num;
  logic [31:0] prm_wdata, prm_rdata_r;
  logic pos_mode = 1'b0;
  logic pos_above_home = 1'b0;
  logic [15:0] status2_in = 16'h0000;
  logic [15:0] feature_in = 16'h0000;
  logic [15:0] slip_in = 16'h0000, speed_frac_in = 16'h0000, fb_speed_frac_in = 16'h0000, travel_frac_in = 16'h0000;
  logic [31:0] speed_whole_in = 32'h0, fb_speed_whole_in = 32'h0, travel_whole_in = 32'h0;
  logic fault_vld = 1'b0;
  dsb_fault_code_t fault_code = 7'h00;
  dsb_layout_t word_layout;
  logic [15:0] status2_word;
  dsb_fault_code_t [2:0] fault_recent;
  logic fault_recorded;
  // bench state
  int mismatches = 0;
  int n_checks = 0;
  dsb_fault_code_t exp_h [10];
  logic [31:0] lim [7];
  logic [31:0] rd;
  logic er, ok;
  int k;

  // 50 MHz clock
  always #10 core_clk = ~core_clk;

  dsb_bank u_dsb_bank (.core_clk(core_clk), .rst(rst), .prm_req(prm_req), .prm_we(prm_we), .prm_num(prm_num),
    .prm_wdata(prm_wdata), .prm_ack_r(prm_ack_r), .prm_err_r(prm_err_r), .prm_rdata_r(prm_rdata_r),
    .pos_mode(pos_mode), .pos_above_home(pos_above_home), .status2_in(status2_in), .feature_in(feature_in),
    .slip_in(slip_in), .speed_whole_in(speed_whole_in), .speed_frac_in(speed_frac_in),
    .fb_speed_whole_in(fb_speed_whole_in), .fb_speed_frac_in(fb_speed_frac_in),
    .travel_whole_in(travel_whole_in), .travel_frac_in(travel_frac_in), .fault_vld(fault_vld),
    .fault_code(fault_code), .word_layout(word_layout), .status2_word(status2_word),
    .fault_recent(fault_recent), .fault_recorded(fault_recorded));

  dsb_host u_dsb_host (.core_clk(core_clk), .prm_ack_r(prm_ack_r), .prm_err_r(prm_err_r),
    .prm_rdata_r(prm_rdata_r), .prm_req(prm_req), .prm_we(prm_we), .prm_num(prm_num), .prm_wdata(prm_wdata));

  // verdict and end of run
  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim

  // counted compare
  task chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, g, x);
    end
  endtask : chk

  // access with error check; d is write data or expected read data
  task xs(input logic we, input logic [8:0] n, input logic [31:0] d, input logic e);
    u_dsb_host.acc(we, n, d, rd, er, ok);
    if (!ok) begin
      mismatches++;
      $display("unexpected at %0t: no answer", $time);
      end_sim();
    end
    chk({31'h0, er}, {31'h0, e});
    if (!we) begin
      chk(rd, d);
    end
  endtask : xs

  // monitors: in range values pass, out of range values clamp to maximum
  task mon_run(input logic over);
    logic [31:0] v [7];
    int i;
    for (i = 0; i < 7; i++) begin
      v[i] = over ? lim[i] + 32'(i + 1) : lim[i] - 32'(i);
    end
    @(negedge core_clk);
    slip_in = v[0][15:0];
    speed_whole_in = v[1];
    speed_frac_in = v[2][15:0];
    fb_speed_whole_in = v[3];
    fb_speed_frac_in = v[4][15:0];
    travel_whole_in = v[5];
    travel_frac_in = v[6][15:0];
    @(negedge core_clk);
    for (i = 0; i < 7; i++) begin
      xs(1'b0, `DSB_PN_SLIP + 9'(i), over ? lim[i] : v[i], 1'b0);
    end
  endtask : mon_run

  // one fault report, recorded or ignored
  task flt(input dsb_fault_code_t c, input logic exp_rec);
    int j;
    @(negedge core_clk);
    fault_vld = 1'b1;
    fault_code = c;
    #1;
    chk({31'h0, fault_recorded}, {31'h0, exp_rec});
    if (exp_rec) begin
      for (j = 9; j > 0; j--) begin
        exp_h[j] = exp_h[j - 1];
      end
      exp_h[0] = c;
    end
    @(negedge core_clk);
    fault_vld = 1'b0;
    fault_code = ~c;
  endtask : flt

  // whole history: slots one to three on ports, four to ten by reads
  task hist_chk;
    int j;
    for (j = 0; j < 3; j++) begin
      chk({25'h0, fault_recent[j]}, {25'h0, exp_h[j]});
    end
    for (j = 3; j < 10; j++) begin
      xs(1'b0, `DSB_PN_HIST_FIRST + 9'(j - 3), {25'h0, exp_h[j]}, 1'b0);
    end
  endtask : hist_chk

  // main sequence
  initial begin
    lim = '{{16'h0, `DSB_SLIP_MAX}, `DSB_SPEED_MAX, {16'h0, `DSB_TENTHS_MAX}, `DSB_SPEED_MAX,
            {16'h0, `DSB_TENTHS_MAX}, `DSB_SPEED_MAX, {16'h0, `DSB_HUNDREDTHS_MAX}};
    for (k = 0; k < 10; k++) begin
      exp_h[k] = `DSB_FAULT_NONE;
    end
    repeat (20) @(negedge core_clk);
    rst = 1'b0;
    xs(1'b0, `DSB_PN_LAYOUT, 32'h0, 1'b0);
    chk({31'h0, word_layout}, {31'h0, DSB_LAYOUT_VELOCITY});
    xs(1'b1, `DSB_PN_LAYOUT, 32'h1, 1'b0);
    chk({31'h0, word_layout}, {31'h0, DSB_LAYOUT_POSITION});
    xs(1'b1, `DSB_PN_LAYOUT, 32'h2, 1'b1);
    xs(1'b0, `DSB_PN_LAYOUT, 32'h1, 1'b0);
    xs(1'b1, `DSB_PN_LAYOUT, 32'h0, 1'b0);
    chk({31'h0, word_layout}, {31'h0, DSB_LAYOUT_VELOCITY});
    // monitors refuse writes; unmapped numbers refused
    xs(1'b1, `DSB_PN_SLIP, 32'h5, 1'b1);
    xs(1'b0, 9'h100, 32'h0, 1'b1);
    mon_run(1'b0);
    mon_run(1'b1);
    // home side shown in bit 10 only in positioning mode
    status2_in = 16'ha5a5;
    feature_in = 16'h3c3c;
    repeat (2) @(negedge core_clk);
    xs(1'b0, `DSB_PN_STATUS2, 32'h0000a5a5, 1'b0);
    xs(1'b0, `DSB_PN_FEATURE, 32'h00003c3c, 1'b0);
    pos_mode = 1'b1;
    repeat (2) @(negedge core_clk);
    chk({16'h0, status2_word}, 32'h0000a1a5);
    status2_in = 16'h5a5a;
    pos_above_home = 1'b1;
    repeat (2) @(negedge core_clk);
    xs(1'b0, `DSB_PN_STATUS2, 32'h00005e5a, 1'b0);
    // empty history, then shifting past ten entries
    hist_chk();
    for (k = 1; k <= 12; k++) begin
      flt(7'(k * 10 + 1), 1'b1);
    end
    hist_chk();
    // repeats and out of range codes are not recorded
    flt(7'd121, 1'b0);
    flt(`DSB_FAULT_NONE, 1'b0);
    flt(7'h7b, 1'b0);
    flt(`DSB_FAULT_MAX, 1'b1);
    flt(7'd121, 1'b1);
    xs(1'b1, `DSB_PN_HIST_LAST, 32'h7, 1'b1);
    hist_chk();
    end_sim();
  end
endmodule : tb_dsb_bank
